// [verilog/stmr_pkg.sv]
package stmr_pkg;
    // register numbers
    localparam logic [3:0] REG_CONFIG   = 4'h1;
    localparam logic [3:0] REG_LOOPBACK = 4'h2;
    localparam logic [3:0] REG_CHANNEL  = 4'h3;
    localparam logic [3:0] REG_CMDIND   = 4'h4;
    // command code in the upper nibble of the first byte
    localparam logic [3:0] CMD_CODE     = 4'h8;
    localparam logic [7:0] READ_REQ     = 8'h80;
    // configuration field positions
    localparam int CFG_MF_DIS_POS     = 7;
    localparam int CFG_STATE_MODE_POS = 5;
    localparam int CFG_LOOP_POS       = 4;
    localparam int CFG_SQ_MODE_POS    = 3;
    localparam int CFG_RX_EN_POS      = 2;
    localparam int CFG_CLKP_POS       = 1;
    // writable bits of the configuration byte; bits 6 and 0 read zero
    localparam logic [7:0] CFG_WMASK = 8'hbe;
    localparam logic [7:0] RESET_VAL = 8'h00;

    typedef enum logic [1:0] {
        stmr_idle_s  = 2'b00,
        stmr_wdata_s = 2'b01,
        stmr_raddr_s = 2'b10,
        stmr_resp_s  = 2'b11
    } stmr_state_t;
endpackage

// [verilog/stmr_regfile.sv]
`timescale 1ns/1ns
module stmr_regfile (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [3:0] rd_addr,
    output logic      [7:0] rd_data,
    output logic            rd_hit,
    output logic      [7:0] cfg
);
    logic [7:0] regs [1:4];

    genvar i;
    generate
        for (i = 1; i <= 4; i++) begin : g_reg
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    regs[i] <= stmr_pkg::RESET_VAL;
                end else if (wr_en && wr_addr == 4'(i)) begin
                    // configuration keeps its fixed zero bits
                    regs[i] <= (i == 1) ? (wr_data & stmr_pkg::CFG_WMASK) : wr_data;
                end
            end
        end
    endgenerate

    always_comb begin
        rd_hit  = (rd_addr >= stmr_pkg::REG_CONFIG)
               && (rd_addr <= stmr_pkg::REG_CMDIND);
        rd_data = rd_hit ? regs[rd_addr[2:0] == 3'h0 ? 1 : int'(rd_addr)] : 8'h00;
    end

    assign cfg = regs[1];
endmodule

// [verilog/stmr_access.sv]
// Operation
// - exactly four registers, numbered one to four
// - registers reached only by monitor commands
// - write: 1000 plus address, then data
// - read request: 80h, then zero nibble address
// - valid read request produces a response
// - response: 1000 plus address, then data
// - configuration register at address one, read/write
// - configuration byte bit layout fixed
// - multiframe disable suspends multiframe synchronisation
`timescale 1ns/1ns
module stmr_access (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       mon_rx_valid,
    input  wire logic [7:0] mon_rx_byte,
    output logic            mon_tx_valid,
    output logic      [7:0] mon_tx_byte,
    output logic            multiframe_sync_disable,
    output logic            state_machine_mode_select,
    output logic            loop_enable,
    output logic            s_q_channel_mode,
    output logic            receive_enable,
    output logic            clock_phase_select
);
    typedef struct packed {
        stmr_pkg::stmr_state_t st;
        logic [3:0]            addr;
        logic [7:0]            data;
        logic                  tx_valid;
        logic [7:0]            tx_byte;
        logic [5:0]            cfg_out;
    } stmr_ctl_t;

    stmr_ctl_t  r;
    stmr_ctl_t  next_r;
    logic       wr_en;
    logic [7:0] rd_data;
    logic       rd_hit;
    logic [7:0] cfg;

    // the only write path into the registers is the command decoder
    stmr_regfile u_regs (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wr_en    (wr_en),
        .wr_addr  (r.addr),
        .wr_data  (mon_rx_byte),
        .rd_addr  (r.addr),
        .rd_data  (rd_data),
        .rd_hit   (rd_hit),
        .cfg      (cfg)
    );

    always_comb begin
        next_r   = r;
        wr_en    = 1'b0;
        next_r.tx_valid = 1'b0;
        next_r.cfg_out  = {cfg[stmr_pkg::CFG_MF_DIS_POS], cfg[stmr_pkg::CFG_STATE_MODE_POS],
                           cfg[stmr_pkg::CFG_LOOP_POS], cfg[stmr_pkg::CFG_SQ_MODE_POS],
                           cfg[stmr_pkg::CFG_RX_EN_POS], cfg[stmr_pkg::CFG_CLKP_POS]};
        case (r.st)
            stmr_pkg::stmr_idle_s: begin
                if (mon_rx_valid) begin
                    if (mon_rx_byte == stmr_pkg::READ_REQ) begin
                        next_r.st = stmr_pkg::stmr_raddr_s;
                    end else if (mon_rx_byte[7:4] == stmr_pkg::CMD_CODE) begin
                        next_r.addr = mon_rx_byte[3:0];
                        next_r.st   = stmr_pkg::stmr_wdata_s;
                    end
                end
            end
            stmr_pkg::stmr_wdata_s: begin
                if (mon_rx_valid) begin
                    wr_en     = rd_hit;
                    next_r.st = stmr_pkg::stmr_idle_s;
                end
            end
            stmr_pkg::stmr_raddr_s: begin
                if (mon_rx_valid) begin
                    next_r.addr = mon_rx_byte[3:0];
                    if (mon_rx_byte[7:4] == 4'h0) begin
                        next_r.st = stmr_pkg::stmr_resp_s;
                    end else begin
                        next_r.st = stmr_pkg::stmr_idle_s;
                    end
                end
            end
            stmr_pkg::stmr_resp_s: begin
                if (rd_hit) begin
                    next_r.data     = rd_data;
                    next_r.tx_valid = 1'b1;
                    next_r.tx_byte  = {stmr_pkg::CMD_CODE, r.addr};
                    next_r.st       = stmr_pkg::stmr_wdata_s;
                    next_r.addr     = 4'h0;
                end else begin
                    next_r.st = stmr_pkg::stmr_idle_s;
                end
                if (r.addr == 4'h0 && r.tx_valid) begin
                    next_r.st = stmr_pkg::stmr_idle_s;
                end
            end
            default: next_r.st = stmr_pkg::stmr_idle_s;
        endcase
        // second response byte follows the first on the next cycle
        if (r.tx_valid && r.tx_byte[7:4] == stmr_pkg::CMD_CODE && r.st == stmr_pkg::stmr_wdata_s
            && r.addr == 4'h0) begin
            next_r.tx_valid = 1'b1;
            next_r.tx_byte  = r.data;
            next_r.st       = stmr_pkg::stmr_idle_s;
            wr_en           = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign mon_tx_valid              = r.tx_valid;
    assign mon_tx_byte               = r.tx_byte;
    assign multiframe_sync_disable   = r.cfg_out[5];
    assign state_machine_mode_select = r.cfg_out[4];
    assign loop_enable               = r.cfg_out[3];
    assign s_q_channel_mode          = r.cfg_out[2];
    assign receive_enable            = r.cfg_out[1];
    assign clock_phase_select        = r.cfg_out[0];

    property p_resp_second;
        @(posedge core_clk) disable iff (!rstn)
            (r.st == stmr_pkg::stmr_resp_s && rd_hit) |=> mon_tx_valid ##1 mon_tx_valid;
    endproperty
    a_resp_second: assert property (p_resp_second)
        else $error("response not two bytes");

    property p_resp_head;
        @(posedge core_clk) disable iff (!rstn)
            (r.st == stmr_pkg::stmr_resp_s && rd_hit) |=> mon_tx_byte[7:4] == 4'h8;
    endproperty
    a_resp_head: assert property (p_resp_head)
        else $error("bad response head");

    property p_no_resp_bad;
        @(posedge core_clk) disable iff (!rstn)
            (r.st == stmr_pkg::stmr_resp_s && !rd_hit) |=> !mon_tx_valid;
    endproperty
    a_no_resp_bad: assert property (p_no_resp_bad)
        else $error("response to bad address");

    property p_read_start;
        @(posedge core_clk) disable iff (!rstn)
            (r.st == stmr_pkg::stmr_idle_s && mon_rx_valid && mon_rx_byte == 8'h80)
            |=> r.st == stmr_pkg::stmr_raddr_s;
    endproperty
    a_read_start: assert property (p_read_start)
        else $error("read request not taken");

    property p_write_start;
        @(posedge core_clk) disable iff (!rstn)
            (r.st == stmr_pkg::stmr_idle_s && mon_rx_valid && mon_rx_byte[7:4] == 4'h8
             && mon_rx_byte[3:0] != 4'h0) |=> r.st == stmr_pkg::stmr_wdata_s;
    endproperty
    a_write_start: assert property (p_write_start)
        else $error("write not taken");

    property p_bad_code;
        @(posedge core_clk) disable iff (!rstn)
            (r.st == stmr_pkg::stmr_idle_s && mon_rx_valid && mon_rx_byte[7:4] != 4'h8)
            |=> r.st == stmr_pkg::stmr_idle_s;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("bad code accepted");

    property p_cfg_zero;
        @(posedge core_clk) disable iff (!rstn)
            (cfg[6] == 1'b0) && (cfg[0] == 1'b0);
    endproperty
    a_cfg_zero: assert property (p_cfg_zero)
        else $error("fixed config bit set");

    property p_mf_dis_follow;
        @(posedge core_clk) disable iff (!rstn)
            ##1 multiframe_sync_disable == $past(cfg[7]);
    endproperty
    a_mf_dis_follow: assert property (p_mf_dis_follow)
        else $error("multiframe disable output stale");

    // the response must name the register that was asked for
    property p_resp_addr;
        @(posedge core_clk) disable iff (!rstn)
            (r.st == stmr_pkg::stmr_resp_s && rd_hit) |=> mon_tx_byte[3:0] == $past(r.addr);
    endproperty
    a_resp_addr: assert property (p_resp_addr)
        else $error("response address not echoed");

    property p_resp_data;
        @(posedge core_clk) disable iff (!rstn)
            (r.st == stmr_pkg::stmr_resp_s && rd_hit)
            |=> ##1 mon_tx_byte == $past(rd_data, 2);
    endproperty
    a_resp_data: assert property (p_resp_data)
        else $error("response data differs from register");

    property p_two_bytes_only;
        @(posedge core_clk) disable iff (!rstn)
            (mon_tx_valid ##1 mon_tx_valid) |=> !mon_tx_valid;
    endproperty
    a_two_bytes_only: assert property (p_two_bytes_only)
        else $error("response longer than two bytes");

    property p_cfg_write;
        @(posedge core_clk) disable iff (!rstn)
            (r.st == stmr_pkg::stmr_wdata_s && mon_rx_valid
             && r.addr == stmr_pkg::REG_CONFIG)
            |=> cfg == ($past(mon_rx_byte) & stmr_pkg::CFG_WMASK);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("configuration write lost");

    // a data byte aimed elsewhere must leave the configuration alone
    property p_other_write;
        @(posedge core_clk) disable iff (!rstn)
            (r.st == stmr_pkg::stmr_wdata_s && mon_rx_valid
             && r.addr != stmr_pkg::REG_CONFIG)
            |=> $stable(cfg);
    endproperty
    a_other_write: assert property (p_other_write)
        else $error("configuration changed by foreign write");

    property p_out_follow;
        @(posedge core_clk) disable iff (!rstn)
            1'b1 |=> {state_machine_mode_select, loop_enable, s_q_channel_mode, receive_enable,
                      clock_phase_select} == $past(cfg[5:1]);
    endproperty
    a_out_follow: assert property (p_out_follow)
        else $error("configuration outputs stale");
endmodule

// [testbench/stmr_ctl_model.sv]
`timescale 1ns/1ns
module stmr_ctl_model (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    output logic            mon_rx_valid,
    output logic      [7:0] mon_rx_byte,
    input  wire logic       mon_tx_valid,
    input  wire logic [7:0] mon_tx_byte
);
    logic [7:0] rsp[$];
    initial begin
        mon_rx_valid = 1'b0;
        mon_rx_byte  = 8'h00;
    end
    // one byte per pulse, line shows inverted data once released
    task automatic send(input logic [7:0] b);
        @(posedge core_clk);
        mon_rx_valid <= 1'b1;
        mon_rx_byte  <= b;
        @(posedge core_clk);
        mon_rx_valid <= 1'b0;
        mon_rx_byte  <= ~b;
    endtask
    always @(posedge core_clk) begin
        if (rstn && mon_tx_valid === 1'b1) begin
            rsp.push_back(mon_tx_byte);
        end
    end
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("[FAIL] %0t got %h exp %h", $time, g, e); \
    end \
end
module tb_top;
    logic       core_clk;
    logic       rstn;
    logic       mon_rx_valid;
    logic [7:0] mon_rx_byte;
    logic       mon_tx_valid;
    logic [7:0] mon_tx_byte;
    logic [5:0] cfg_out;
    int         n_mismatch;
    int         num_checks;
    int         cycles;
    stmr_access DUT (.core_clk(core_clk), .rstn(rstn), .mon_rx_valid(mon_rx_valid),
        .mon_rx_byte(mon_rx_byte), .mon_tx_valid(mon_tx_valid), .mon_tx_byte(mon_tx_byte),
        .multiframe_sync_disable(cfg_out[5]), .state_machine_mode_select(cfg_out[4]),
        .loop_enable(cfg_out[3]), .s_q_channel_mode(cfg_out[2]),
        .receive_enable(cfg_out[1]), .clock_phase_select(cfg_out[0]));
    stmr_ctl_model ctl (.core_clk(core_clk), .rstn(rstn), .mon_rx_valid(mon_rx_valid),
        .mon_rx_byte(mon_rx_byte), .mon_tx_valid(mon_tx_valid), .mon_tx_byte(mon_tx_byte));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        ctl.send({stmr_pkg::CMD_CODE, a});
        ctl.send(d);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] b2, input logic [7:0] exp, input bit resp);
        ctl.rsp.delete();
        ctl.send(stmr_pkg::READ_REQ);
        ctl.send(b2);
        repeat (5) @(posedge core_clk);
        if (resp) begin
            `CHK(ctl.rsp.size(), 2)
            `CHK(ctl.rsp[0], {4'h8, b2[3:0]})
            `CHK(ctl.rsp[1], exp)
        end else begin
            `CHK(ctl.rsp.size(), 0)
        end
    endtask
    task automatic test_cfg();
        logic [7:0] d[8] = '{8'hff, 8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h41};
        foreach (d[i]) begin
            wr(4'h1, d[i]);
            `CHK(cfg_out, {d[i][7], d[i][5:1]})
            rd(8'h01, d[i] & 8'hbe, 1'b1);
        end
        $display("test cfg done");
    endtask
    task automatic test_regs();
        for (int a = 1; a <= 4; a++) begin
            wr(a[3:0], 8'h5a ^ a[7:0]);
        end
        rd(8'h01, (8'h5a ^ 8'h01) & 8'hbe, 1'b1);
        for (int a = 2; a <= 4; a++) begin
            rd({4'h0, a[3:0]}, 8'h5a ^ a[7:0], 1'b1);
        end
        $display("test regs done");
    endtask
    task automatic test_ignore();
        wr(4'h1, 8'h3c);
        ctl.send(8'h91);
        ctl.send(8'hff);
        wr(4'h5, 8'hff);
        wr(4'hf, 8'hff);
        rd(8'h00, 8'h00, 1'b0);
        rd(8'h05, 8'h00, 1'b0);
        rd(8'h11, 8'h00, 1'b0);
        rd(8'h01, 8'h3c, 1'b1);
        $display("test ignore done");
    endtask
    task automatic test_rst();
        wr(4'h1, 8'hff);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK(cfg_out, 6'h00)
        rstn <= 1'b1;
        rd(8'h01, 8'h00, 1'b1);
        $display("test reset done");
    endtask
    initial begin
        rstn         = 1'b0;
        n_mismatch   = 0;
        num_checks   = 0;
        cycles       = 0;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        rd(8'h01, 8'h00, 1'b1);
        test_cfg();
        test_regs();
        test_ignore();
        test_rst();
        results();
    end
endmodule
